// ---- stepper_bridge_control_and_faults.sv ----
// Control, chopping, bridge gating and fault logic of a two-phase stepper driver.
`timescale 1ns/10ps
// Overview of operation
// R1 - Angle reset control high forces electrical angle to initial state; low runs normally.
// R2 - During reset angle is 45 degrees; current 100% full/half-a, else 71%.
// R3 - Torque select LL/LH/HL/HH gives 100/75/50/25 percent.
// R4 - Home flag pulls low at initial angle, released otherwise.
// R5 - General fault flag is open drain, low after thermal or over-current trip.
// R6 - Thermal fault flag is open drain, low only after thermal shutdown.
// R7 - Faults clear only by supply reapplication or a sleep-and-wake cycle.
// R8 - Forward current: charge H1+L2, fast H2+L1, slow both low sides.
// R9 - Reverse current: charge H2+L1, fast H1+L2, slow both low sides.
// R10 - Every gating change passes through an all-off cross-conduction interval.
// R11 - Default chopping oscillator runs at 914 kHz, chopping at 57.1 kHz; here a tick every 43 clocks gives about 930 kHz and 58.1 kHz.
// R12 - Over-temperature must persist 5.0 us, then latches and forces outputs off.
// R13 - Over-current trips immediately, forces all outputs off, and latches.
// R14 - Supply under-voltage disables operation, resuming automatically once supply is good.
// R15 - One chopping cycle is sixteen oscillator ticks.
// R16 - Fast decay lasts six ticks; slow decay fills the rest of the cycle.
// R17 - Decay and direction settings change only at the next chopping cycle start.
// R18 - Reset clears latched faults; sleep entry also releases both flags.
// R19 - Any latched fault or under-voltage holds all eight gates off.
module stepper_bridge_control_and_faults
  import stepper_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  // Analog sense indications
  input  wire logic        overtemp_sense,
  input  wire logic        overcurrent_sense,
  input  wire logic        motor_supply_ok,
  input  wire logic        nf_reached_a,
  input  wire logic        nf_reached_b,
  // Open-drain flags
  output logic             angle_home_flag_out,
  output logic             angle_home_flag_oe,
  output logic             fault_flag_any_out,
  output logic             fault_flag_any_oe,
  output logic             fault_flag_thermal_out,
  output logic             fault_flag_thermal_oe,
  // Current scaling
  output logic [6:0]       torque_pct,
  output logic [6:0]       hold_current_pct,
  // Bridge gates, channel A then B
  output logic             high_side_one_a,
  output logic             high_side_two_a,
  output logic             low_side_one_a,
  output logic             low_side_two_a,
  output logic             high_side_one_b,
  output logic             high_side_two_b,
  output logic             low_side_one_b,
  output logic             low_side_two_b
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Gate order is {high one, high two, low one, low two}.
  function automatic logic [3:0] gate_of(input phase_type ph, input logic rev);
    logic [3:0] g;
    g = 4'h3;
    if (ph == PH_CHARGE) begin
      g = rev ? 4'h6 : 4'h9; // [R8] [R9]
    end else if (ph == PH_FAST) begin
      g = rev ? 4'h9 : 4'h6; // [R8] [R9]
    end
    return g;
  endfunction
  function automatic logic [6:0] step_size(input logic [2:0] res);
    logic [6:0] s;
    s = 7'h01;
    case (res)
      RES_FULL:                s = 7'h20;
      RES_HALF_A, RES_HALF_B:  s = 7'h10;
      RES_QUARTER:             s = 7'h08;
      RES_EIGHTH:              s = 7'h04;
      RES_SIXTEENTH:           s = 7'h02;
      default:                 s = 7'h01;
    endcase
    return s;
  endfunction
  function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] wd, input logic be);
    return be ? wd : old;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [10:0] ctrl, next_ctrl;
  logic [3:0]  irq_stat, next_irq_stat;
  logic [3:0]  irq_mask, next_irq_mask;
  logic [6:0]  angle, next_angle;
  logic        access;
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  logic        sleep_q, tsd_lat, isd_lat, next_tsd_lat, next_isd_lat;
  logic [7:0]  ot_cnt, next_ot_cnt;
  logic        supply_undervoltage_lockout_q, home_q;
  logic [5:0]  osc_cnt, next_osc_cnt;
  logic [3:0]  chop_cnt, next_chop_cnt;
  logic        fast_en, next_fast_en;
  logic [1:0]  dir, next_dir;
  phase_type   phase [2], next_phase [2];
  logic [3:0]  fast_cnt [2], next_fast_cnt [2];
  logic [3:0]  gate [2], next_gate [2];
  logic [4:0]  dead [2], next_dead [2];
  logic [6:0]  next_torque, next_hold;
  logic [3:0]  events;
  logic        tick, halt, sleep_rise;
  logic [1:0]  nf;

  assign tick       = (osc_cnt == 6'(OSC_CYC - 1)); // [R11]
  assign sleep_rise = ctrl[CTRL_SLEEP] & ~sleep_q;
  assign halt       = tsd_lat | isd_lat | ~motor_supply_ok | ctrl[CTRL_SLEEP]; // [R19] [R14]
  assign nf         = {nf_reached_b, nf_reached_a};
  assign access     = (avs_read | avs_write) & ~avs_waitrequest;
  // ---------------------------------------------------------------
  // Register bus, angle and interrupts
  // ---------------------------------------------------------------
  always_comb begin
    next_ctrl        = ctrl;
    next_irq_mask    = irq_mask;
    next_angle       = angle;
    next_readdata    = avs_readdata;
    // One wait cycle per access, then waitrequest returns high.
    next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
    events = '0;
    events[EV_TSD]  = next_tsd_lat & ~tsd_lat;
    events[EV_ISD]  = next_isd_lat & ~isd_lat;
    events[EV_SUPPLY_UNDERVOLTAGE_LOCKOUT] = ~motor_supply_ok & ~supply_undervoltage_lockout_q;
    events[EV_HOME] = (angle == ANGLE_INIT) & ~home_q;
    next_irq_stat = irq_stat;
    if (avs_read & avs_waitrequest) begin
      case (avs_address)
        ADDR_CTRL:   next_readdata = {21'h0, ctrl};
        ADDR_STATUS: next_readdata = {16'h0, 1'b0, angle, 4'h0, home_q, ~motor_supply_ok, isd_lat, tsd_lat};
        ADDR_IRQ:    next_readdata = {28'h0, irq_stat};
        ADDR_MASK:   next_readdata = {28'h0, irq_mask};
        default:     next_readdata = 32'h0;
      endcase
    end
    if (access & avs_write) begin
      if (avs_address == ADDR_CTRL) begin
        next_ctrl[7:0]  = lane_merge(ctrl[7:0], avs_writedata[7:0], avs_byteenable[0]);
        next_ctrl[CTRL_RES +: 3] = avs_byteenable[1] ? avs_writedata[CTRL_RES +: 3] : ctrl[CTRL_RES +: 3];
      end
      if (avs_address == ADDR_IRQ && avs_byteenable[0]) begin
        next_irq_stat = irq_stat & ~avs_writedata[3:0];
      end
      if (avs_address == ADDR_MASK && avs_byteenable[0]) begin
        next_irq_mask = avs_writedata[3:0];
      end
      if (avs_address == ADDR_STEP && avs_byteenable[0] && avs_writedata[STEP_GO]) begin
        next_angle = avs_writedata[STEP_BACK] ? angle - step_size(ctrl[CTRL_RES +: 3])
                                              : angle + step_size(ctrl[CTRL_RES +: 3]);
      end
    end
    // Set wins over a clear written in the same cycle.
    next_irq_stat = next_irq_stat | events;
    if (ctrl[CTRL_RESET]) begin
      next_angle = ANGLE_INIT; // [R1] [R2]
    end
    case (ctrl[CTRL_TRQ_H:CTRL_TRQ_L])
      2'b00:   next_torque = PCT_FULL; // [R3]
      2'b01:   next_torque = PCT_75;
      2'b10:   next_torque = PCT_50;
      default: next_torque = PCT_25;
    endcase
    if (ctrl[CTRL_RES +: 3] == RES_FULL || ctrl[CTRL_RES +: 3] == RES_HALF_A) begin
      next_hold = PCT_FULL; // [R2]
    end else begin
      next_hold = PCT_71;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl            <= CTRL_RST_VAL;
      irq_stat        <= '0;
      irq_mask        <= '0;
      angle           <= ANGLE_INIT;
      avs_readdata    <= '0;
      avs_waitrequest <= 1'b1;
      irq             <= 1'b0;
      torque_pct      <= PCT_FULL;
      hold_current_pct <= PCT_FULL;
      supply_undervoltage_lockout_q          <= 1'b0;
      home_q          <= 1'b1;
    end else begin
      ctrl            <= next_ctrl;
      irq_stat        <= next_irq_stat;
      irq_mask        <= next_irq_mask;
      angle           <= next_angle;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      irq             <= |(next_irq_stat & next_irq_mask);
      torque_pct      <= next_torque;
      hold_current_pct <= next_hold;
      supply_undervoltage_lockout_q          <= ~motor_supply_ok;
      home_q          <= (angle == ANGLE_INIT);
    end
  end

  // ---------------------------------------------------------------
  // Faults, chopping and bridge gating
  // ---------------------------------------------------------------
  always_comb begin
    next_tsd_lat  = tsd_lat;
    next_isd_lat  = isd_lat;
    next_ot_cnt   = overtemp_sense ? ot_cnt + 8'h01 : 8'h00;
    // A fault still present at sleep entry latches again, so the set wins over the clear.
    if (sleep_rise) begin
      next_tsd_lat = 1'b0; // [R7] [R18]
      next_isd_lat = 1'b0;
    end
    if (ot_cnt == 8'(TSD_CYC - 1) && overtemp_sense) begin
      next_tsd_lat = 1'b1; // [R12]
      next_ot_cnt  = ot_cnt;
    end
    if (overcurrent_sense) begin
      next_isd_lat = 1'b1; // [R13]
    end
    next_osc_cnt  = tick ? 6'h00 : osc_cnt + 6'h01;
    next_chop_cnt = tick ? chop_cnt + 4'h1 : chop_cnt; // [R15]
    next_fast_en  = fast_en;
    next_dir      = dir;
    for (int c = 0; c < 2; c++) begin
      next_phase[c]    = phase[c];
      next_fast_cnt[c] = fast_cnt[c];
      next_gate[c]     = gate[c];
      next_dead[c]     = dead[c];
    end
    // Settings are sampled only at a cycle boundary so a cycle never mixes two modes.
    if (tick && chop_cnt == CHOP_LAST) begin
      next_fast_en = ctrl[CTRL_FAST]; // [R17]
      next_dir     = {ctrl[CTRL_DIR_B], ctrl[CTRL_DIR_A]};
    end
    for (int c = 0; c < 2; c++) begin
      unique case (phase[c])
        PH_CHARGE: begin
          if (nf[c]) begin
            next_phase[c]    = fast_en ? PH_FAST : PH_SLOW; // [R16]
            next_fast_cnt[c] = FAST_TICKS;
          end
        end
        PH_FAST: begin
          if (tick) begin
            next_fast_cnt[c] = fast_cnt[c] - 4'h1;
            if (fast_cnt[c] == 4'h1) begin
              next_phase[c] = PH_SLOW; // [R16]
            end
          end
        end
        default: begin
          next_phase[c] = PH_SLOW;
        end
      endcase
      if (tick && chop_cnt == CHOP_LAST) begin
        next_phase[c] = PH_CHARGE; // [R15]
      end
      if (halt) begin
        next_gate[c] = 4'h0; // [R19] [R12] [R13]
        next_dead[c] = 5'(XCOND_CYC);
      end else if (gate_of(phase[c], dir[c]) != gate[c]) begin
        if (gate[c] != 4'h0) begin
          next_gate[c] = 4'h0; // [R10]
          next_dead[c] = 5'(XCOND_CYC);
        end else if (dead[c] != 5'h00) begin
          next_dead[c] = dead[c] - 5'h01; // [R10]
        end else begin
          next_gate[c] = gate_of(phase[c], dir[c]);
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sleep_q  <= 1'b0;
      tsd_lat  <= 1'b0; // [R18]
      isd_lat  <= 1'b0;
      ot_cnt   <= '0;
      osc_cnt  <= '0;
      chop_cnt <= '0;
      fast_en  <= 1'b1;
      dir      <= '0;
      for (int c = 0; c < 2; c++) begin
        phase[c]    <= PH_SLOW;
        fast_cnt[c] <= '0;
        gate[c]     <= '0;
        dead[c]     <= 5'(XCOND_CYC);
      end
      angle_home_flag_oe    <= 1'b0;
      fault_flag_any_oe     <= 1'b0;
      fault_flag_thermal_oe <= 1'b0;
    end else begin
      sleep_q  <= ctrl[CTRL_SLEEP];
      tsd_lat  <= next_tsd_lat;
      isd_lat  <= next_isd_lat;
      ot_cnt   <= next_ot_cnt;
      osc_cnt  <= next_osc_cnt;
      chop_cnt <= next_chop_cnt;
      fast_en  <= next_fast_en;
      dir      <= next_dir;
      for (int c = 0; c < 2; c++) begin
        phase[c]    <= next_phase[c];
        fast_cnt[c] <= next_fast_cnt[c];
        gate[c]     <= next_gate[c];
        dead[c]     <= next_dead[c];
      end
      angle_home_flag_oe    <= (next_angle == ANGLE_INIT); // [R4]
      fault_flag_any_oe     <= next_tsd_lat | next_isd_lat; // [R5]
      fault_flag_thermal_oe <= next_tsd_lat; // [R6]
    end
  end

  // ---------------------------------------------------------------
  // Pin mapping
  // ---------------------------------------------------------------
  // Open-drain pins only ever pull low, so the data bit stays zero.
  assign angle_home_flag_out    = 1'b0;
  assign fault_flag_any_out     = 1'b0;
  assign fault_flag_thermal_out = 1'b0;
  assign {high_side_one_a, high_side_two_a, low_side_one_a, low_side_two_a} = gate[0];
  assign {high_side_one_b, high_side_two_b, low_side_one_b, low_side_two_b} = gate[1];

endmodule

// ---- stepper_pkg.sv ----
// Shared constants for the stepper bridge control block.
package stepper_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 40000000;
  localparam int OSC_HZ      = 914000;
  localparam int CHOP_HZ_X10 = 571;
  localparam int OSC_CYC     = CLK_HZ / OSC_HZ;
  localparam int TSD_DEAD_NS = 5000;
  localparam int TSD_CYC     = (TSD_DEAD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int XCOND_NS    = 500;
  localparam int XCOND_CYC   = (XCOND_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0] CHOP_LAST  = 4'hF;
  localparam logic [3:0] FAST_TICKS = 4'h6;
  // ---------------------------------------------------------------
  // Angle, torque and current
  // ---------------------------------------------------------------
  localparam logic [6:0] ANGLE_INIT = 7'h10;
  localparam logic [6:0] PCT_FULL   = 7'h64;
  localparam logic [6:0] PCT_71     = 7'h47;
  localparam logic [6:0] PCT_75     = 7'h4B;
  localparam logic [6:0] PCT_50     = 7'h32;
  localparam logic [6:0] PCT_25     = 7'h19;
  typedef enum logic [2:0] {
    RES_FULL = 3'b000, RES_HALF_A = 3'b001, RES_HALF_B = 3'b010, RES_QUARTER = 3'b011,
    RES_EIGHTH = 3'b100, RES_SIXTEENTH = 3'b101, RES_THIRTYSECOND = 3'b110
  } res_type;
  typedef enum logic [1:0] {
    PH_CHARGE = 2'b00, PH_FAST = 2'b01, PH_SLOW = 2'b10
  } phase_type;
  // ---------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_STEP   = 5'h04;
  localparam logic [4:0] ADDR_STATUS = 5'h08;
  localparam logic [4:0] ADDR_IRQ    = 5'h0C;
  localparam logic [4:0] ADDR_MASK   = 5'h10;
  localparam int CTRL_RESET = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_TRQ_L = 2;
  localparam int CTRL_TRQ_H = 3;
  localparam int CTRL_DIR_A = 4;
  localparam int CTRL_DIR_B = 5;
  localparam int CTRL_FAST  = 6;
  localparam int CTRL_RES   = 8;
  localparam int STEP_GO    = 0;
  localparam int STEP_BACK  = 1;
  localparam logic [10:0] CTRL_RST_VAL = 11'h041;
  localparam int EV_TSD  = 0;
  localparam int EV_ISD  = 1;
  localparam int EV_SUPPLY_UNDERVOLTAGE_LOCKOUT = 2;
  localparam int EV_HOME = 3;
endpackage

// ---- stepper_sva.sv ----
// Port-level assertions for the stepper bridge control block.
`timescale 1ns/10ps
module stepper_sva
  import stepper_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [4:0]  avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  // Senses and flags
  input wire logic        overtemp_sense,
  input wire logic        overcurrent_sense,
  input wire logic        fault_flag_any_oe,
  input wire logic        fault_flag_thermal_oe,
  input wire logic        angle_home_flag_out,
  input wire logic        fault_flag_any_out,
  input wire logic        fault_flag_thermal_out,
  // Scaling and gates
  input wire logic [6:0]  torque_pct,
  input wire logic [6:0]  hold_current_pct,
  input wire logic        high_side_one_a,
  input wire logic        high_side_two_a,
  input wire logic        low_side_one_a,
  input wire logic        low_side_two_a,
  input wire logic        high_side_one_b,
  input wire logic        high_side_two_b,
  input wire logic        low_side_one_b,
  input wire logic        low_side_two_b
);
  wire [3:0] ga = {high_side_one_a, high_side_two_a, low_side_one_a, low_side_two_a};
  wire [3:0] gb = {high_side_one_b, high_side_two_b, low_side_one_b, low_side_two_b};
  wire wr_ctrl = avs_write & ~avs_waitrequest & (avs_address == ADDR_CTRL);
  logic [7:0] ot_cnt;
  logic [7:0] next_ot_cnt;
  // Saturating run length of the raw over-temperature level.
  always_comb begin
    next_ot_cnt = (overtemp_sense && ot_cnt != 8'hFF) ? ot_cnt + 8'h01 : ot_cnt;
    if (!overtemp_sense) next_ot_cnt = 8'h00;
  end
  always_ff @(posedge clk_sys) begin
    ot_cnt <= rst ? 8'h00 : next_ot_cnt;
  end
  function automatic logic ok_pat(logic [3:0] p);
    return p inside {4'h0, 4'h9, 4'h6, 4'h3};
  endfunction
  function automatic logic [6:0] tq(logic [1:0] s);
    return s == 2'h0 ? PCT_FULL : s == 2'h1 ? PCT_75 : s == 2'h2 ? PCT_50 : PCT_25;
  endfunction
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_legal_patterns: assert property (ok_pat(ga) && ok_pat(gb))
    else $error("illegal bridge gate pattern");
  a_dead_gap: assert property ((ga != $past(ga) && $past(ga) != 4'h0 |-> ga == 4'h0)
    and (gb != $past(gb) && $past(gb) != 4'h0 |-> gb == 4'h0)) else $error("gate change without gap");
  a_fault_gates_off: assert property ($past(fault_flag_any_oe) |-> ga == 4'h0 && gb == 4'h0)
    else $error("gates on during fault");
  a_flags_drive_low: assert property (!angle_home_flag_out && !fault_flag_any_out && !fault_flag_thermal_out)
    else $error("open-drain flag drives high");
  a_thermal_any: assert property (fault_flag_thermal_oe |-> fault_flag_any_oe)
    else $error("thermal flag without general flag");
  a_oc_latch: assert property (overcurrent_sense |=> fault_flag_any_oe)
    else $error("over-current not latched");
  a_ot_dead_band: assert property ($rose(fault_flag_thermal_oe) |-> $past(ot_cnt) >= 8'(TSD_CYC - 1))
    else $error("thermal trip too early");
  a_ot_trips: assert property (ot_cnt == 8'(TSD_CYC + 5) |-> fault_flag_thermal_oe)
    else $error("thermal trip missing");
  a_flag_clear: assert property ($fell(fault_flag_any_oe) |-> $past(wr_ctrl) || $past(wr_ctrl, 2)
    || $past(wr_ctrl, 3)) else $error("fault flag cleared without sleep");
  a_torque_map: assert property (wr_ctrl && avs_byteenable[0] |-> ##2 torque_pct == tq($past(avs_writedata[3:2], 2)))
    else $error("torque scaling wrong");
  a_hold_map: assert property (wr_ctrl && avs_byteenable[1] |-> ##2
    hold_current_pct == ($past(avs_writedata[10:8], 2) < 3'h2 ? PCT_FULL : PCT_71)) else $error("hold current wrong");
  c_thermal: cover property ($rose(fault_flag_thermal_oe));
  c_overcurrent: cover property ($rose(fault_flag_any_oe) && !fault_flag_thermal_oe);
  c_fast_decay: cover property (ga == 4'h6);
endmodule
bind stepper_bridge_control_and_faults stepper_sva chk_u (.*);

// ---- winding_model.sv ----
// Winding current comparator model on the far side of the bridges.
`timescale 1ns/10ps
module winding_model #(parameter int CHG_LEN = 30) (
  input  wire logic       clk_sys,
  input  wire logic [3:0] ga,
  input  wire logic [3:0] gb,
  output logic            nf_a,
  output logic            nf_b
);
  int ca = 0;
  int cb = 0;
  // Current builds only while a high side conducts, so the level drops at once when the bridge goes off.
  always_ff @(posedge clk_sys) begin
    ca <= (ga[3] | ga[2]) ? ca + 1 : 0;
    cb <= (gb[3] | gb[2]) ? cb + 1 : 0;
  end
  assign nf_a = ca >= CHG_LEN;
  assign nf_b = cb >= CHG_LEN;
endmodule

// ---- test_stepper_bridge_control_and_faults.sv ----
// Self-checking testbench for the stepper bridge control block.
`timescale 1ns/10ps
module test_stepper_bridge_control_and_faults;
  import stepper_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0;
  logic [4:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        avs_waitrequest, irq, overtemp_sense = 0, overcurrent_sense = 0, motor_supply_ok = 1;
  logic        nf_reached_a, nf_reached_b, angle_home_flag_out, angle_home_flag_oe;
  logic        fault_flag_any_out, fault_flag_any_oe, fault_flag_thermal_out, fault_flag_thermal_oe;
  logic [6:0]  torque_pct, hold_current_pct;
  logic        high_side_one_a, high_side_two_a, low_side_one_a, low_side_two_a;
  logic        high_side_one_b, high_side_two_b, low_side_one_b, low_side_two_b;
  wire  [3:0]  ga = {high_side_one_a, high_side_two_a, low_side_one_a, low_side_two_a};
  wire  [3:0]  gb = {high_side_one_b, high_side_two_b, low_side_one_b, low_side_two_b};
  logic [6:0]  tq [4] = '{PCT_FULL, PCT_75, PCT_50, PCT_25};
  int          err_total = 0, cmp_count = 0, n, tot;
  stepper_bridge_control_and_faults dut_u (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .overtemp_sense,
    .overcurrent_sense, .motor_supply_ok, .nf_reached_a, .nf_reached_b, .angle_home_flag_out,
    .angle_home_flag_oe, .fault_flag_any_out, .fault_flag_any_oe, .fault_flag_thermal_out,
    .fault_flag_thermal_oe, .torque_pct, .hold_current_pct, .high_side_one_a, .high_side_two_a,
    .low_side_one_a, .low_side_two_a, .high_side_one_b, .high_side_two_b, .low_side_one_b, .low_side_two_b);
  winding_model wm_u (.clk_sys(clk_sys), .ga(ga), .gb(gb), .nf_a(nf_reached_a), .nf_b(nf_reached_b));
  always #12.5 clk_sys = ~clk_sys;
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // One Avalon access; the request stands until the edge that samples waitrequest low.
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    check("bus wait cycles", k, 2);
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk_sys);
  endtask
  // Waits for a channel A gate pattern, adding the cycles spent to tot.
  task automatic wait_a(logic [3:0] p, int lim);
    n = 0;
    while (ga !== p && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    tot += n;
    check("gate A pattern", ga, p);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_reset();
    bus(0, ADDR_CTRL, 0);
    check("ctrl reset value", rd[10:0], CTRL_RST_VAL);
    check("torque at reset", torque_pct, PCT_FULL);
    check("home flag at reset", angle_home_flag_oe, 1);
    bus(0, ADDR_STATUS, 0);
    check("initial angle", rd[14:8], ANGLE_INIT);
    bus(0, 5'h14, 32'h0);
    check("unmapped read", rd, 0);
  endtask
  task automatic s_scale();
    for (int i = 0; i < 7; i++) begin
      bus(1, ADDR_CTRL, 32'h41 | (i % 4) << 2 | i << 8);
      tick(2);
      check("torque", torque_pct, tq[i % 4]);
      check("hold current", hold_current_pct, i < 2 ? PCT_FULL : PCT_71);
    end
  endtask
  task automatic s_home();
    bus(1, ADDR_CTRL, 32'h40);
    bus(1, ADDR_STEP, 32'h1);
    tick(2);
    check("home released", angle_home_flag_oe, 0);
    bus(0, ADDR_STATUS, 0);
    check("stepped angle", rd[14:8], ANGLE_INIT + 7'h20);
    bus(1, ADDR_CTRL, 32'h41);
    tick(2);
    check("home after reset", angle_home_flag_oe, 1);
    bus(1, ADDR_CTRL, 32'h40);
  endtask
  task automatic s_chop();
    // Start from slow decay so that the charge seen next heads a fresh cycle.
    wait_a(4'h3, 800);
    wait_a(4'h9, 800);
    tot = 0;
    wait_a(4'h0, 200);
    wait_a(4'h6, 40);
    n = tot;
    wait_a(4'h0, 400);
    wait_a(4'h3, 40);
    check("fast span", tot - n >= (FAST_TICKS - 1) * OSC_CYC &&
      tot - n <= FAST_TICKS * OSC_CYC + XCOND_CYC + 2, 1);
    wait_a(4'h9, 800);
    check("chop cycle", tot, 16 * OSC_CYC);
    bus(1, ADDR_CTRL, 32'h50);
    wait_a(4'h6, 200);
    wait_a(4'h0, 400);
    wait_a(4'h3, 40);
    wait_a(4'h6, 800);
    wait_a(4'h0, 200);
    wait_a(4'h9, 40);
  endtask
  task automatic s_fault();
    bus(1, ADDR_MASK, 32'h0);
    overcurrent_sense <= 1;
    tick(1);
    overcurrent_sense <= 0;
    tick(3);
    check("any flag", fault_flag_any_oe, 1);
    check("thermal flag", fault_flag_thermal_oe, 0);
    check("gates off", {ga, gb}, 0);
    check("masked irq", irq, 0);
    bus(1, ADDR_MASK, 32'h2);
    tick(2);
    check("irq", irq, 1);
    bus(1, ADDR_IRQ, 32'h2);
    tick(2);
    check("irq cleared", irq, 0);
    tick(900);
    check("flag latched", fault_flag_any_oe, 1);
    bus(1, ADDR_CTRL, 32'h42);
    bus(1, ADDR_CTRL, 32'h40);
    tick(2);
    check("flag cleared", fault_flag_any_oe, 0);
  endtask
  task automatic s_thermal();
    overtemp_sense <= 1;
    tick(150);
    overtemp_sense <= 0;
    tick(3);
    check("short overtemp", fault_flag_thermal_oe, 0);
    overtemp_sense <= 1;
    tick(250);
    overtemp_sense <= 0;
    check("thermal flag", fault_flag_thermal_oe, 1);
    check("any flag", fault_flag_any_oe, 1);
    bus(1, ADDR_CTRL, 32'h42);
    bus(1, ADDR_CTRL, 32'h40);
    tick(2);
    check("flags cleared", {fault_flag_any_oe, fault_flag_thermal_oe}, 0);
  endtask
  task automatic s_supply_undervoltage_lockout();
    motor_supply_ok <= 0;
    tick(3);
    check("gates off", {ga, gb}, 0);
    bus(0, ADDR_STATUS, 0);
    check("undervoltage status", rd[2], 1);
    motor_supply_ok <= 1;
    wait_a(4'h6, 800);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    tick(2);
    rst <= 0;
    tick(1);
    s_reset();
    s_scale();
    s_home();
    s_chop();
    s_fault();
    s_thermal();
    s_supply_undervoltage_lockout();
    print_verdict();
  end
  // The whole run needs some 3500 cycles; 40000 leaves ample margin.
  initial begin
    #1000000;
    err_total++;
    print_verdict();
  end
endmodule
